/* File: imsc_pkg.sv */
// Shared constants for the two-wire master sequence control block
package imsc_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [4:0] IMSC_IDX_MODE  = 5'h10;  // Mode select
  localparam logic [4:0] IMSC_IDX_BUF   = 5'h11;  // Transmit/receive buffer
  localparam logic [4:0] IMSC_IDX_CTRL2 = 5'h12;  // Second control register
  localparam logic [4:0] IMSC_IDX_STAT  = 5'h13;  // Engine status
  localparam logic [4:0] IMSC_IDX_IRQ   = 5'h14;  // Sticky event flags
  localparam logic [4:0] IMSC_IDX_MASK  = 5'h15;  // Event mask

  // Bit positions in the second control register
  localparam int IMSC_B_GENERAL_CALL_ENABLE    = 7;  // General call enable
  localparam int IMSC_B_ACK_STATUS = 6;  // Acknowledge status
  localparam int IMSC_B_ACK_DATA_VALUE   = 5;  // Acknowledge data value
  localparam int IMSC_B_ACK_SEQUENCE_ENABLE   = 4;  // Acknowledge sequence enable
  localparam int IMSC_B_RECEIVE_ENABLE    = 3;  // Receive enable
  localparam int IMSC_B_PEN     = 2;  // Stop enable
  localparam int IMSC_B_REPEATED_START_ENABLE    = 1;  // Repeated start enable
  localparam int IMSC_B_SEN     = 0;  // Start enable

  localparam logic [7:0] IMSC_CTRL2_RST = 8'h00;  // Power-on value
  localparam logic [4:0] IMSC_SEQ_ZERO  = 5'h00;  // No sequence bit set
  localparam logic [7:0] IMSC_GC_ADDR   = 8'h00;  // General call address byte
  localparam logic [7:0] IMSC_BYTE_ZERO = 8'h00;  // Cleared byte

  // Event flag positions
  localparam int IMSC_IRQ_DONE = 0;  // Master sequence finished
  localparam int IMSC_IRQ_GC   = 1;  // General call address seen
  localparam int IMSC_IRQ_NACK = 2;  // Slave did not acknowledge
  localparam int IMSC_IRQ_W    = 3;  // Number of event flags

  // Bus timing
  localparam int IMSC_CLK_NS    = 100;    // System clock period
  localparam int IMSC_SCL_NS    = 10000;  // Serial clock period
  localparam int IMSC_QTR_CYC   = IMSC_SCL_NS / 4 / IMSC_CLK_NS;  // Quarter bit, rounded down
  localparam logic [2:0] IMSC_LAST_BIT = 3'h7;  // Last bit of a byte

  // Quarter phases of one bus slot
  localparam logic [1:0] IMSC_PH_LOW  = 2'h0;  // Clock low, data set
  localparam logic [1:0] IMSC_PH_RISE = 2'h1;  // Clock released
  localparam logic [1:0] IMSC_PH_HIGH = 2'h2;  // Clock high, data sampled
  localparam logic [1:0] IMSC_PH_FALL = 2'h3;  // Clock pulled low

  // Master engine states
  typedef enum logic [2:0] {
    IMSC_IDLE, IMSC_START, IMSC_RSTART, IMSC_STOP,
    IMSC_TX, IMSC_TXACK, IMSC_RX, IMSC_ACK
  } imsc_state_t;

endpackage

/* File: imsc_sync.sv */
// Two-flop synchroniser for bus pins
`timescale 1ns/1ns
module imsc_sync #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // One chain per bit; idle bus reads high
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        meta_q[i]   <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule

/* File: imsc_top.sv */
// Two-wire master sequence control with Avalon-MM registers
`timescale 1ns/1ns
module imsc_top
  import imsc_pkg::*;
#(
  parameter int QTR_CYC = IMSC_QTR_CYC,  // System clocks per quarter bit
  parameter int AW      = 5               // Word address width
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [AW-1:0] avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  output logic               irq,
  input  wire logic          scl_i,
  output logic               scl_o,
  output logic               scl_oe,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] pins_s;  // {scl, sda} after two flops
  logic       scl_s;   // Synchronised clock line
  logic       sda_s;   // Synchronised data line

  imsc_sync #(.W(2)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({scl_i, sda_i}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  //////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]             ctrl2_q;     // Second control register
  logic                   master_q;    // Mode: 1 master, 0 slave
  logic [7:0]             buf_q;       // Transmit/receive buffer
  logic                   tx_go_q;     // Buffer written, byte pending
  logic [IMSC_IRQ_W-1:0]  irq_st_q;    // Sticky events
  logic [IMSC_IRQ_W-1:0]  irq_mask_q;  // Event mask
  imsc_state_t            st_q;        // Master engine state
  logic [15:0]            qcnt_q;      // Quarter-bit counter
  logic [1:0]             ph_q;        // Quarter phase
  logic [2:0]             bitn_q;      // Bit within byte
  logic [7:0]             sh_q;        // Master shift register
  logic                   samp_q;      // Data sampled at high phase
  logic                   scl_low_q;   // Drive clock low
  logic                   sda_low_q;   // Drive data low
  logic                   lvl_q;       // Driven level, always low
  logic                   scl_p_q;     // Previous clock sample
  logic                   sda_p_q;     // Previous data sample
  logic                   sl_act_q;    // Slave address byte in progress
  logic [2:0]             sl_cnt_q;    // Slave bit count
  logic [6:0]             sl_sh_q;     // Slave address shift

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire        wr_acc   = avs_write & ~avs_waitrequest;
  wire        sel_mode = (avs_address == IMSC_IDX_MODE);
  wire        sel_buf  = (avs_address == IMSC_IDX_BUF);
  wire        sel_ctl  = (avs_address == IMSC_IDX_CTRL2);
  wire        sel_stat = (avs_address == IMSC_IDX_STAT);
  wire        sel_irq  = (avs_address == IMSC_IDX_IRQ);
  wire        sel_mask = (avs_address == IMSC_IDX_MASK);
  wire        idle     = (st_q == IMSC_IDLE);
  wire [7:0]  wdat     = avs_writedata[7:0];
  wire [4:0]  wseq     = wdat[IMSC_B_ACK_SEQUENCE_ENABLE:IMSC_B_SEN];
  // Only the highest-priority request bit is kept, nothing is queued
  wire [4:0]  wseq_one = wseq & (5'h00 - wseq);
  wire        seq_ok   = idle & master_q;

  // Read mux; unmapped indexes read zero
  wire [7:0]  rd_byte  = sel_mode ? {7'h00, master_q} :
                         sel_buf  ? buf_q :
                         sel_ctl  ? ctrl2_q :
                         sel_stat ? {6'h00, sl_act_q, idle} :
                         sel_irq  ? {5'h00, irq_st_q} :
                         sel_mask ? {5'h00, irq_mask_q} : IMSC_BYTE_ZERO;

  //////////////////////////////////////////////////////////////////////////////
  // Engine timing
  wire stretch = (ph_q == IMSC_PH_RISE) & ~scl_s & ~idle;  // Slave holds clock
  wire tick    = ~idle & ~stretch & (qcnt_q == 16'(QTR_CYC - 1));
  wire slot_end = tick & (ph_q == IMSC_PH_FALL);
  wire samp_now = tick & (ph_q == IMSC_PH_HIGH);
  wire last_bit = (bitn_q == IMSC_LAST_BIT);

  // Launch decisions from idle, in master mode only
  wire go_sen  = idle & master_q & ctrl2_q[IMSC_B_SEN];
  wire go_repeated_start_enable = idle & master_q & ctrl2_q[IMSC_B_REPEATED_START_ENABLE];
  wire go_pen  = idle & master_q & ctrl2_q[IMSC_B_PEN];
  wire go_receive_enable = idle & master_q & ctrl2_q[IMSC_B_RECEIVE_ENABLE];
  wire go_ack  = idle & master_q & ctrl2_q[IMSC_B_ACK_SEQUENCE_ENABLE];
  wire go_tx   = idle & master_q & tx_go_q;

  // Finishing events
  wire fin_any  = slot_end & ((st_q == IMSC_START) | (st_q == IMSC_RSTART) |
                              (st_q == IMSC_STOP) | (st_q == IMSC_ACK) |
                              (st_q == IMSC_TXACK) | ((st_q == IMSC_RX) & last_bit));
  wire fin_rx   = slot_end & (st_q == IMSC_RX) & last_bit;
  wire fin_txak = slot_end & (st_q == IMSC_TXACK);
  wire nack_ev  = fin_txak & samp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive table per state and phase
  wire ph_lo   = (ph_q == IMSC_PH_LOW);
  wire ph_late = (ph_q == IMSC_PH_HIGH) | (ph_q == IMSC_PH_FALL);
  wire bit_val = (st_q == IMSC_TX)  ? sh_q[7] :
                 (st_q == IMSC_ACK) ? ctrl2_q[IMSC_B_ACK_DATA_VALUE] : 1'b1;
  wire scl_low_d =
      (st_q == IMSC_START)  ? (ph_q == IMSC_PH_FALL) :
      (st_q == IMSC_RSTART) ? (ph_lo | (ph_q == IMSC_PH_FALL)) :
      (st_q == IMSC_STOP)   ? ph_lo :
      (st_q == IMSC_IDLE)   ? (scl_low_q & master_q) :
                              (ph_lo | (ph_q == IMSC_PH_FALL));
  wire sda_low_d =
      (st_q == IMSC_START)  ? ph_late :
      (st_q == IMSC_RSTART) ? ph_late :
      (st_q == IMSC_STOP)   ? ~ph_late :
      (st_q == IMSC_IDLE)   ? (sda_low_q & master_q) :
                              ~bit_val;

  //////////////////////////////////////////////////////////////////////////////
  // Slave address watcher
  wire start_seen = scl_s & sda_p_q & ~sda_s;
  wire scl_rise   = scl_s & ~scl_p_q;
  wire sl_byte    = sl_act_q & scl_rise & (sl_cnt_q == IMSC_LAST_BIT);
  wire gc_ev      = ~master_q & ctrl2_q[IMSC_B_GENERAL_CALL_ENABLE] & sl_byte &
                    ({sl_sh_q, sda_s} == IMSC_GC_ADDR);

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= {24'h00_0000, rd_byte};
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Mode and mask registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      master_q   <= 1'b0;
      irq_mask_q <= '0;
    end else begin
      if (wr_acc & sel_mode) master_q <= wdat[0];
      if (wr_acc & sel_mask) irq_mask_q <= wdat[IMSC_IRQ_W-1:0];
    end
  end

  // Second control register: software writes, hardware clears
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl2_q <= IMSC_CTRL2_RST;
    end else begin
      if (wr_acc & sel_ctl) begin
        ctrl2_q[7:5] <= wdat[7:5];
        if (seq_ok) begin
          ctrl2_q[IMSC_B_ACK_SEQUENCE_ENABLE:IMSC_B_SEN] <= wseq_one;
        end
      end
      // Hardware clears the request bit once its sequence is done
      if (slot_end & (st_q != IMSC_TX) & (st_q != IMSC_TXACK) &
          ((st_q != IMSC_RX) | last_bit)) begin
        ctrl2_q[IMSC_B_ACK_SEQUENCE_ENABLE:IMSC_B_SEN] <= IMSC_SEQ_ZERO;
      end
      // Acknowledge result from the slave; hardware wins over software
      if (fin_txak) begin
        ctrl2_q[IMSC_B_ACK_STATUS] <= samp_q;
      end
    end
  end

  // Buffer: written by software when idle, loaded by a received byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_q   <= IMSC_BYTE_ZERO;
      tx_go_q <= 1'b0;
    end else begin
      if (wr_acc & sel_buf & idle) begin
        buf_q   <= wdat;
        tx_go_q <= master_q;
      end else if (go_tx & ~go_sen & ~go_repeated_start_enable & ~go_pen & ~go_receive_enable & ~go_ack) begin
        tx_go_q <= 1'b0;
      end
      if (fin_rx) buf_q <= sh_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master engine state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q   <= IMSC_IDLE;
      bitn_q <= 3'h0;
    end else if (idle) begin
      bitn_q <= 3'h0;
      if (go_sen)       st_q <= IMSC_START;
      else if (go_repeated_start_enable) st_q <= IMSC_RSTART;
      else if (go_pen)  st_q <= IMSC_STOP;
      else if (go_receive_enable) st_q <= IMSC_RX;
      else if (go_ack)  st_q <= IMSC_ACK;
      else if (go_tx)   st_q <= IMSC_TX;
    end else if (slot_end) begin
      unique case (st_q)
        IMSC_TX: begin
          bitn_q <= bitn_q + 3'h1;
          if (last_bit) st_q <= IMSC_TXACK;
        end
        IMSC_RX: begin
          bitn_q <= bitn_q + 3'h1;
          if (last_bit) st_q <= IMSC_IDLE;
        end
        default: begin
          st_q <= IMSC_IDLE;
        end
      endcase
    end
  end

  // Quarter counter and phase
  always_ff @(posedge sys_clk) begin
    if (rst | idle) begin
      qcnt_q <= 16'h0000;
      ph_q   <= IMSC_PH_LOW;
    end else if (tick) begin
      qcnt_q <= 16'h0000;
      ph_q   <= ph_q + 2'h1;
    end else if (!stretch) begin
      qcnt_q <= qcnt_q + 16'h0001;
    end
  end

  // Shift register and data sample
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh_q   <= IMSC_BYTE_ZERO;
      samp_q <= 1'b1;
    end else if (go_tx & idle) begin
      sh_q <= buf_q;
    end else begin
      if (samp_now) samp_q <= sda_s;
      if (samp_now & (st_q == IMSC_RX)) sh_q <= {sh_q[6:0], sda_s};
      if (slot_end & (st_q == IMSC_TX)) sh_q <= {sh_q[6:0], 1'b0};
    end
  end

  // Registered pin drive; enables high while pulling low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      lvl_q     <= 1'b0;
    end else begin
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      lvl_q     <= 1'b0;
    end
  end
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;
  assign scl_o  = lvl_q;
  assign sda_o  = lvl_q;

  //////////////////////////////////////////////////////////////////////////////
  // Slave address watcher state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
      sl_act_q <= 1'b0;
      sl_cnt_q <= 3'h0;
      sl_sh_q  <= 7'h00;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (master_q) begin
        sl_act_q <= 1'b0;
      end else if (start_seen) begin
        sl_act_q <= 1'b1;
        sl_cnt_q <= 3'h0;
      end else if (sl_act_q & scl_rise) begin
        sl_sh_q  <= {sl_sh_q[5:0], sda_s};
        sl_cnt_q <= sl_cnt_q + 3'h1;
        if (sl_byte) sl_act_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky events: set wins over write-one-to-clear
  wire [IMSC_IRQ_W-1:0] ev_set = {nack_ev, gc_ev, fin_any};
  wire [IMSC_IRQ_W-1:0] ev_clr = (wr_acc & sel_irq) ? wdat[IMSC_IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_st_q <= '0;
      irq      <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~ev_clr) | ev_set;
      irq      <= |(((irq_st_q & ~ev_clr) | ev_set) & irq_mask_q);
    end
  end

endmodule

/* File: imsc_checker.sv */
// Port-level assertions for the two-wire master sequence control block
`timescale 1ns/1ns
module imsc_checker
  import imsc_pkg::*;
#(
  parameter int QTR_CYC = 2,  // System clocks per quarter bit
  parameter int AW      = 5   // Word address width
) (
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic [AW-1:0] avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_writedata,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire logic          irq,
  input wire logic          scl_i,
  input wire logic          scl_o,
  input wire logic          scl_oe,
  input wire logic          sda_i,
  input wire logic          sda_o,
  input wire logic          sda_oe
);
  localparam int SEQ_MAX = 16 * QTR_CYC + 8;  // Longest wait for a line event
  localparam int REL_MIN = 4 * QTR_CYC;       // Release longer than any data slot
  ////////////////////////////////////////////////////////////////////////////////
  logic        master_q;  // Mode as last written
  logic [7:0]  mask_q;    // Event mask as last written
  logic [15:0] rel_q;     // Cycles with both lines released
  logic [15:0] rel_d;     // Next release count
  wire wr_acc  = avs_write && !avs_waitrequest;                        // Write takes effect
  wire wr_mode = wr_acc && (avs_address == AW'(IMSC_IDX_MODE));        // Mode write
  wire wr_mask = wr_acc && (avs_address == AW'(IMSC_IDX_MASK));        // Mask write
  wire wr_ctrl = wr_acc && (avs_address == AW'(IMSC_IDX_CTRL2)) && master_q;  // Master ctrl
  assign rel_d = (scl_oe || sda_oe) ? 16'h0000 : ((&rel_q) ? rel_q : rel_q + 16'h0001);
  // Track mode, mask and line idle time
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      master_q <= 1'b0;
      mask_q   <= 8'h00;
      rel_q    <= 16'h0000;
    end else begin
      master_q <= wr_mode ? avs_writedata[0] : master_q;
      mask_q   <= wr_mask ? avs_writedata[7:0] : mask_q;
      rel_q    <= rel_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  rst_pins_a: assert property (disable iff (1'b0) rst |=>
    avs_waitrequest && !irq && !scl_oe && !sda_oe) else $error("outputs not idle after reset");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("access not answered in one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rdata_high_a: assert property (avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  od_zero_a: assert property (!scl_o && !sda_o) else $error("line driven high");
  start_gen_a: assert property (wr_ctrl && avs_writedata[0] && rel_q > REL_MIN
    |-> ##[1:SEQ_MAX] ($rose(sda_oe) && !scl_oe)) else $error("no start condition");
  stop_gen_a: assert property (wr_ctrl && avs_writedata[2:0] == 3'h4
    |-> ##[1:SEQ_MAX] ($fell(sda_oe) && !scl_oe)) else $error("no stop condition");
  slave_quiet_a: assert property (!master_q && !$past(master_q) |->
    !scl_oe && !sda_oe) else $error("lines driven in slave mode");
  irq_mask_a: assert property ((mask_q == 8'h00) [*2] |-> !irq)
    else $error("interrupt with all events masked");
endmodule

bind imsc_top imsc_checker #(.QTR_CYC(QTR_CYC), .AW(AW)) i_imsc_checker (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

/* File: imsc_slave.sv */
// Behavioural two-wire slave: acks, sends bytes, issues a general call
`timescale 1ns/1ns
module imsc_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  input  wire logic       rd_mode,
  input  wire logic [7:0] tx_byte,
  output logic            scl_pull,
  output logic            sda_pull
);
  int         cnt     = 9;     // Bit slot, -1 after start, 9 when idle
  int         starts  = 0;     // Start and repeated start count
  int         stops   = 0;     // Stop count
  logic [7:0] rxb     = 8'h00; // Byte clocked in from the master
  logic       ack_bit = 1'b0;  // Level seen in the master's ack slot
  logic       scl_gc  = 1'b0;  // Clock pull while issuing a frame
  logic       sda_gc  = 1'b0;  // Data pull while issuing a frame
  // Start and stop spotted as data edges while the clock is high
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = -1;
    starts++;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    cnt = 9;
    stops++;
  end
  // Count clock falls into nine-slot bytes
  always @(negedge scl) if (cnt < 9) cnt = (cnt == 8) ? 0 : cnt + 1;
  // Sample data bits and the master's ack bit
  always @(posedge scl) begin
    if (cnt >= 0 && cnt < 8) rxb = {rxb[6:0], sda};
    if (cnt == 8) ack_bit = sda;
  end
  // Ack a written byte or drive a byte being read; released line floats high
  assign sda_pull = sda_gc || (cnt == 8 && !rd_mode && ack_en) ||
                    (rd_mode && cnt >= 0 && cnt < 8 && !tx_byte[7-cnt]);
  assign scl_pull = scl_gc;
  // Issue start, one byte, a released ack slot and stop at an 800 ns clock
  task automatic gen_call(input logic [7:0] b);
    int i;
    sda_gc = 1'b1;
    #400 scl_gc = 1'b1;
    for (i = 0; i < 9; i++) begin
      sda_gc = (i < 8) ? !b[7-i] : 1'b0;
      #400 scl_gc = 1'b0;
      #400 scl_gc = 1'b1;
    end
    sda_gc = 1'b1;
    #400 scl_gc = 1'b0;
    #400 sda_gc = 1'b0;
    #400;
  endtask
endmodule

/* File: imsc_top_tb.sv */
// Self-checking testbench for the two-wire master sequence control block
`timescale 1ns/1ns
module imsc_top_tb
  import imsc_pkg::*;
;
  logic        sys_clk, rst, avs_read, avs_write, ack_en, rd_mode;  // Bench drives
  logic [4:0]  avs_address;    // Word index
  logic [31:0] avs_writedata;  // Write data
  logic [7:0]  tx_byte;        // Byte the slave sends
  wire  [31:0] avs_readdata;   // Read data
  wire         avs_waitrequest, irq, scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
  wire         scl = !(scl_oe || scl_pull);  // Pulled-up clock line
  wire         sda = !(sda_oe || sda_pull);  // Pulled-up data line
  int          error_cnt = 0;  // Mismatches
  int          n_compared = 0; // Comparisons
  int          i, n0;          // Loop index, counter snapshot
  ////////////////////////////////////////////////////////////////////////////////
  imsc_top #(.QTR_CYC(2), .AW(5)) i_imsc_top (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  imsc_slave i_imsc_slave (.scl(scl), .sda(sda), .ack_en(ack_en), .rd_mode(rd_mode),
    .tx_byte(tx_byte), .scl_pull(scl_pull), .sda_pull(sda_pull));
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Print counts and verdict, then stop
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t ns: %s got %h", $time, m, got);
      error_cnt++;
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      chk(8'h00, 8'h01, "bus timeout");
      test_done();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] exp, input string m);
    logic [7:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(q, exp, m);
  endtask
  // Write, then poll status until the engine is idle
  task automatic run(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    int n;
    wr(a, d);
    n = 0;
    do begin
      bus(IMSC_IDX_STAT, 1'b0, 8'h00, q);
      n++;
    end while (q[0] !== 1'b1 && n < 300);
    if (q[0] !== 1'b1) begin
      chk(8'h00, 8'h01, "idle timeout");
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, ack_en, rd_mode} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    tx_byte = 8'h00;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rc(IMSC_IDX_CTRL2, 8'h00, "ctrl reset");
    wr(5'h01, 8'h5a);
    rc(5'h01, 8'h00, "unmapped");
    wr(IMSC_IDX_CTRL2, 8'hff);
    rc(IMSC_IDX_CTRL2, 8'he0, "slave ctrl");
    $display("test reset done");
    // General call enabled, then disabled, then ignored in master mode
    wr(IMSC_IDX_MASK, 8'h02);
    wr(IMSC_IDX_CTRL2, 8'h80);
    i_imsc_slave.gen_call(IMSC_GC_ADDR);
    rc(IMSC_IDX_IRQ, 8'h02, "gc flag");
    chk({7'h00, irq}, 8'h01, "gc irq");
    wr(IMSC_IDX_IRQ, 8'h07);
    rc(IMSC_IDX_IRQ, 8'h00, "flag clear");
    chk({7'h00, irq}, 8'h00, "irq clear");
    wr(IMSC_IDX_CTRL2, 8'h00);
    i_imsc_slave.gen_call(IMSC_GC_ADDR);
    rc(IMSC_IDX_IRQ, 8'h00, "gc off");
    wr(IMSC_IDX_MODE, 8'h01);
    wr(IMSC_IDX_CTRL2, 8'h80);
    i_imsc_slave.gen_call(IMSC_GC_ADDR);
    rc(IMSC_IDX_IRQ, 8'h00, "gc in master");
    $display("test general call done");
    // Start with done flag masked
    wr(IMSC_IDX_MASK, 8'h06);
    n0 = i_imsc_slave.starts;
    run(IMSC_IDX_CTRL2, 8'h01);
    chk(8'(i_imsc_slave.starts - n0), 8'h01, "start seen");
    rc(IMSC_IDX_CTRL2, 8'h00, "start clear");
    rc(IMSC_IDX_IRQ, 8'h01, "done flag");
    chk({7'h00, irq}, 8'h00, "masked irq");
    wr(IMSC_IDX_IRQ, 8'h07);
    wr(IMSC_IDX_MASK, 8'h07);
    // Acked byte with refused requests while busy
    ack_en <= 1'b1;
    wr(IMSC_IDX_BUF, 8'ha5);
    wr(IMSC_IDX_CTRL2, 8'h01);
    run(IMSC_IDX_BUF, 8'h11);
    rc(IMSC_IDX_CTRL2, 8'h00, "ack status and refused start");
    chk(i_imsc_slave.rxb, 8'ha5, "byte on wire");
    rc(IMSC_IDX_BUF, 8'ha5, "buffer kept");
    wr(IMSC_IDX_IRQ, 8'h07);
    // Not acked byte
    ack_en <= 1'b0;
    run(IMSC_IDX_BUF, 8'h5a);
    rc(IMSC_IDX_CTRL2, 8'h40, "nack status");
    rc(IMSC_IDX_IRQ, 8'h05, "nack flag");
    chk({7'h00, irq}, 8'h01, "nack irq");
    wr(IMSC_IDX_IRQ, 8'h07);
    $display("test transmit done");
    // Receive then send not-ack, then ack
    for (i = 0; i < 2; i++) begin
      rd_mode <= 1'b1;
      tx_byte <= (i == 0) ? 8'h3c : 8'hc3;
      run(IMSC_IDX_CTRL2, 8'h08);
      rc(IMSC_IDX_BUF, (i == 0) ? 8'h3c : 8'hc3, "rx byte");
      rd_mode <= 1'b0;
      run(IMSC_IDX_CTRL2, (i == 0) ? 8'h30 : 8'h10);
      chk({7'h00, i_imsc_slave.ack_bit}, (i == 0) ? 8'h01 : 8'h00, "ack bit");
      rc(IMSC_IDX_CTRL2, (i == 0) ? 8'h20 : 8'h00, "ack clear");
    end
    wr(IMSC_IDX_IRQ, 8'h07);
    $display("test receive done");
    // Repeated start, stop, then slave mode refusal
    n0 = i_imsc_slave.starts;
    run(IMSC_IDX_CTRL2, 8'h02);
    chk(8'(i_imsc_slave.starts - n0), 8'h01, "restart seen");
    rc(IMSC_IDX_CTRL2, 8'h00, "restart clear");
    n0 = i_imsc_slave.stops;
    run(IMSC_IDX_CTRL2, 8'h04);
    chk(8'(i_imsc_slave.stops - n0), 8'h01, "stop seen");
    rc(IMSC_IDX_CTRL2, 8'h00, "stop clear");
    wr(IMSC_IDX_MODE, 8'h00);
    wr(IMSC_IDX_CTRL2, 8'h01);
    rc(IMSC_IDX_CTRL2, 8'h00, "slave refuse");
    $display("test sequences done");
    test_done();
  end
endmodule
